// ### rtl/lpmc_pkg.sv
// Constants and carrier types shared by the low-power mode controller
package lpmc_pkg;

    // ------------------------------------------------------------
    // Clock and timing
    // ------------------------------------------------------------
    localparam int unsigned CLK_HZ = 100_000_000;
    localparam int unsigned CYCLES_PER_MS = CLK_HZ / 1000;
    localparam int unsigned CAL_TIME_MS = 10;
    localparam int unsigned CAL_CYCLES = CAL_TIME_MS * CYCLES_PER_MS;
    localparam int unsigned LED_HOLD_MS = 6;
    localparam int unsigned LED_HOLD_CYCLES = LED_HOLD_MS * CYCLES_PER_MS;
    localparam int unsigned CNT_W = 20;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam int unsigned ADDR_W = 10;
    localparam int unsigned DATA_W = 16;
    localparam logic [9:0] IO_BASE_OFFSET = 10'h020;
    localparam logic [9:0] SELF_CONTROL_OFFSET = 10'h100;
    localparam logic [9:0] SELF_STATUS_OFFSET = 10'h104;
    localparam logic [15:0] IO_BASE_RESET = 16'h0000;
    localparam logic [15:0] SELF_CONTROL_RESET = 16'h0000;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int unsigned SOFT_PD_BIT = 8;
    localparam int unsigned PIN_PD_BIT = 9;
    localparam int unsigned LINK_WATCH_BIT = 10;
    localparam int unsigned INIT_DONE_BIT = 7;
    localparam int unsigned SI_BUSY_BIT = 8;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum {
        ST_RESET,
        ST_CAL,
        ST_CFG,
        ST_RUN,
        ST_STANDBY,
        ST_HW_SUSP,
        ST_SW_SUSP
    } lpmc_state_t;

    typedef struct packed {
        logic sel;
        logic wr;
        logic rd;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } lpmc_host_req_t;

    typedef struct packed {
        logic valid;
        logic [DATA_W-1:0] rdata;
    } lpmc_host_rsp_t;

    typedef struct packed {
        logic core_reset;
        logic analog_on;
        logic rx_listen;
        logic core_isolate;
        logic bus_ignore;
        logic net_ignore;
    } lpmc_power_ctl_t;

endpackage

// ### rtl/lpmc_led_stretch.sv
// Activity LED pulse stretcher with a programmable hold time
`timescale 1ns/1ps
`default_nettype none

module lpmc_led_stretch
#(
    parameter int unsigned HOLD_CYCLES = lpmc_pkg::LED_HOLD_CYCLES
)
(
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic trigger,
    output logic led_n
);
    import lpmc_pkg::*;

    // ------------------------------------------------------------
    // Hold counter
    // ------------------------------------------------------------
    localparam logic [CNT_W-1:0] HOLD_LOAD = CNT_W'(HOLD_CYCLES - 1);

    logic [CNT_W-1:0] cnt_reg;
    logic [CNT_W-1:0] cnt_next;
    logic on_reg;
    logic on_next;
    wire logic cnt_zero = (cnt_reg == '0);

    // Every event restarts the full hold, so a burst keeps the LED lit
    assign cnt_next = trigger ? HOLD_LOAD : (cnt_zero ? cnt_reg : cnt_reg - 1'b1);
    assign on_next = trigger | (on_reg & ~cnt_zero);

    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            cnt_reg <= '0;
            on_reg <= 1'b0;
        end
        else
        begin
            cnt_reg <= cnt_next;
            on_reg <= on_next;
        end
    end

    assign led_n = ~on_reg;

endmodule // lpmc_led_stretch

`default_nettype wire

// ### rtl/lpmc_sequencer.sv
// Low-power mode sequencer: standby, suspend, wake-up reset and activity LED
// What this block does
// - Three low-power states, all chosen by self_control enable bits.
// - Leaving any low-power state triggers internal reset, calibration, configuration read.
// - End of self-configuration sets init_complete and clears serial_if_busy.
// - Calibration lasts about 10 ms; host waits for it before register access.
// - Hardware standby needs sleep pin low, pin-powerdown and link-watch bits set.
// - Standby keeps only the link receiver; link activity drives LED low.
// - Host bus accesses are ignored during hardware standby.
// - Entering standby resets all registers except self_control.
// - Raising the sleep pin ends standby with full reset and initialisation.
// - Hardware suspend: sleep pin low, pin-powerdown set, link-watch clear.
// - Hardware suspend isolates core, ignores host bus and network activity.
// - Raising the sleep pin ends hardware suspend with full reset.
// - Software suspend keeps only io_base_address and self_control alive.
// - Any write to device space wakes software suspend; write data discarded.
// - External hardware reset leaves any sleep state.
// - Hardware low-power states override software suspend.
// - LED low on transmit, receive or collision; held at least 6 ms.
`timescale 1ns/1ps
`default_nettype none

module lpmc_sequencer
#(
    parameter int unsigned CAL_CYCLES_P = lpmc_pkg::CAL_CYCLES,
    parameter int unsigned LED_HOLD_CYCLES_P = lpmc_pkg::LED_HOLD_CYCLES
)
(
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic sleep_n_pin,
    input wire logic link_activity_pin,
    input wire logic tx_event,
    input wire logic rx_event,
    input wire logic collision_event,
    input wire logic cfg_load_done,
    input wire lpmc_pkg::lpmc_host_req_t host_req,
    output lpmc_pkg::lpmc_host_rsp_t host_rsp,
    output lpmc_pkg::lpmc_power_ctl_t power_ctl,
    output logic cfg_load_start,
    output logic activity_led_n,
    output logic init_complete,
    output logic serial_if_busy
);
    import lpmc_pkg::*;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic reg_hit(input logic [ADDR_W-1:0] addr, input logic [ADDR_W-1:0] offset);
        reg_hit = (addr == offset);
    endfunction

    localparam logic [CNT_W-1:0] CAL_LAST = CNT_W'(CAL_CYCLES_P - 1);

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    lpmc_state_t state_reg;
    lpmc_state_t state_next;
    logic [CNT_W-1:0] cal_cnt_reg;
    logic [CNT_W-1:0] cal_cnt_next;
    logic [DATA_W-1:0] io_base_reg;
    logic [DATA_W-1:0] io_base_next;
    logic [DATA_W-1:0] self_control_reg;
    logic [DATA_W-1:0] self_control_next;
    logic init_done_reg;
    logic init_done_next;
    logic si_busy_reg;
    logic si_busy_next;
    logic rsp_valid_reg;
    logic [DATA_W-1:0] rsp_data_reg;
    logic [DATA_W-1:0] rd_mux;
    logic sleep_meta_reg;
    logic sleep_n_sync_reg;
    logic link_meta_reg;
    logic link_sync_reg;

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            sleep_meta_reg <= 1'b1;
            sleep_n_sync_reg <= 1'b1;
            link_meta_reg <= 1'b0;
            link_sync_reg <= 1'b0;
        end
        else
        begin
            sleep_meta_reg <= sleep_n_pin;
            sleep_n_sync_reg <= sleep_meta_reg;
            link_meta_reg <= link_activity_pin;
            link_sync_reg <= link_meta_reg;
        end
    end

    // ------------------------------------------------------------
    // State decode
    // ------------------------------------------------------------
    wire logic in_reset = (state_reg == ST_RESET);
    wire logic in_cal = (state_reg == ST_CAL);
    wire logic in_cfg = (state_reg == ST_CFG);
    wire logic in_run = (state_reg == ST_RUN);
    wire logic in_standby = (state_reg == ST_STANDBY);
    wire logic in_hw_susp = (state_reg == ST_HW_SUSP);
    wire logic in_sw_susp = (state_reg == ST_SW_SUSP);
    wire logic awake = in_reset | in_cal | in_cfg | in_run;
    wire logic hw_asleep = in_standby | in_hw_susp;

    // ------------------------------------------------------------
    // Mode selection
    // ------------------------------------------------------------
    wire logic pin_pd_en = self_control_reg[PIN_PD_BIT];
    wire logic link_watch_en = self_control_reg[LINK_WATCH_BIT];
    wire logic soft_pd_req = self_control_reg[SOFT_PD_BIT];
    wire logic hw_sleep = ~sleep_n_sync_reg & pin_pd_en;
    wire logic want_standby = hw_sleep & link_watch_en;
    wire logic want_hw_susp = hw_sleep & ~link_watch_en;
    wire logic want_sw_susp = ~hw_sleep & soft_pd_req;
    wire logic cal_done = (cal_cnt_reg == CAL_LAST);

    // ------------------------------------------------------------
    // Host access decode
    // ------------------------------------------------------------
    wire logic hit_io_base = reg_hit(host_req.addr, IO_BASE_OFFSET);
    wire logic hit_self_ctl = reg_hit(host_req.addr, SELF_CONTROL_OFFSET);
    wire logic hit_self_st = reg_hit(host_req.addr, SELF_STATUS_OFFSET);
    wire logic host_wr = host_req.sel & host_req.wr;
    wire logic host_rd = host_req.sel & host_req.rd;
    wire logic wr_ok = host_wr & awake;
    wire logic wake_write = host_wr & in_sw_susp;
    wire logic rd_ok = host_rd & ~hw_asleep;
    wire logic status_live = ~in_sw_susp;

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb
    begin
        state_next = state_reg;
        case (state_reg)
            ST_RESET, ST_CAL, ST_CFG, ST_RUN:
            begin
                if (want_standby)
                begin
                    state_next = ST_STANDBY;
                end
                else if (want_hw_susp)
                begin
                    state_next = ST_HW_SUSP;
                end
                else if (want_sw_susp)
                begin
                    state_next = ST_SW_SUSP;
                end
                else if (in_reset)
                begin
                    state_next = ST_CAL;
                end
                else if (in_cal && cal_done)
                begin
                    state_next = ST_CFG;
                end
                else if (in_cfg && cfg_load_done)
                begin
                    state_next = ST_RUN;
                end
            end
            ST_STANDBY:
            begin
                if (!hw_sleep)
                begin
                    state_next = ST_RESET;
                end
                else if (!link_watch_en)
                begin
                    state_next = ST_HW_SUSP;
                end
            end
            ST_HW_SUSP:
            begin
                if (!hw_sleep)
                begin
                    state_next = ST_RESET;
                end
                else if (link_watch_en)
                begin
                    state_next = ST_STANDBY;
                end
            end
            ST_SW_SUSP:
            begin
                if (want_standby)
                begin
                    state_next = ST_STANDBY;
                end
                else if (want_hw_susp)
                begin
                    state_next = ST_HW_SUSP;
                end
                else if (wake_write)
                begin
                    state_next = ST_RESET;
                end
            end
            default:
            begin
                state_next = ST_RESET;
            end
        endcase
    end

    wire logic enter_standby = (state_next == ST_STANDBY) & ~in_standby;

    // ------------------------------------------------------------
    // Calibration timer and status flags
    // ------------------------------------------------------------
    assign cal_cnt_next = (in_cal && !cal_done) ? cal_cnt_reg + 1'b1 : '0;
    assign cfg_load_start = in_cal & cal_done & (state_next == ST_CFG);
    // Status flags return to their reset values in every sleep state as well as in the reset state
    assign init_done_next = in_cfg & cfg_load_done ? 1'b1 : ((in_reset | ~awake) ? 1'b0 : init_done_reg);
    assign si_busy_next = in_cfg & cfg_load_done ? 1'b0 : ((in_reset | ~awake) ? 1'b1 : si_busy_reg);

    // ------------------------------------------------------------
    // Register writes
    // ------------------------------------------------------------
    always_comb
    begin
        io_base_next = io_base_reg;
        self_control_next = self_control_reg;
        if (enter_standby)
        begin
            io_base_next = IO_BASE_RESET;
        end
        else if (wr_ok && hit_io_base)
        begin
            io_base_next = host_req.wdata;
        end
        if (wr_ok && hit_self_ctl)
        begin
            self_control_next = host_req.wdata;
        end
        else if (wake_write)
        begin
            // Write data is dropped; the request bit falls so the wake sticks
            self_control_next[SOFT_PD_BIT] = 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------
    always_comb
    begin
        rd_mux = '0;
        if (hit_io_base)
        begin
            rd_mux = io_base_reg;
        end
        else if (hit_self_ctl)
        begin
            rd_mux = self_control_reg;
        end
        else if (hit_self_st && status_live)
        begin
            rd_mux[INIT_DONE_BIT] = init_done_reg;
            rd_mux[SI_BUSY_BIT] = si_busy_reg;
        end
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            state_reg <= ST_RESET;
            cal_cnt_reg <= '0;
            init_done_reg <= 1'b0;
            si_busy_reg <= 1'b1;
        end
        else
        begin
            state_reg <= state_next;
            cal_cnt_reg <= cal_cnt_next;
            init_done_reg <= init_done_next;
            si_busy_reg <= si_busy_next;
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            io_base_reg <= IO_BASE_RESET;
            self_control_reg <= SELF_CONTROL_RESET;
        end
        else
        begin
            io_base_reg <= io_base_next;
            self_control_reg <= self_control_next;
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            rsp_valid_reg <= 1'b0;
            rsp_data_reg <= '0;
        end
        else
        begin
            rsp_valid_reg <= rd_ok;
            rsp_data_reg <= rd_ok ? rd_mux : '0;
        end
    end

    assign host_rsp.valid = rsp_valid_reg;
    assign host_rsp.rdata = rsp_data_reg;
    assign init_complete = init_done_reg;
    assign serial_if_busy = si_busy_reg;

    // ------------------------------------------------------------
    // Power controls
    // ------------------------------------------------------------
    assign power_ctl.core_reset = in_reset | in_standby | in_hw_susp | in_sw_susp;
    assign power_ctl.analog_on = awake;
    assign power_ctl.rx_listen = awake | in_standby;
    assign power_ctl.core_isolate = in_hw_susp;
    assign power_ctl.bus_ignore = hw_asleep;
    assign power_ctl.net_ignore = ~awake;

    // ------------------------------------------------------------
    // Activity LED
    // ------------------------------------------------------------
    // Network events count only when awake; in standby the link receiver alone lights it
    wire logic net_activity = awake & (tx_event | rx_event | collision_event);
    wire logic led_trigger = net_activity | (in_standby & link_sync_reg);

    lpmc_led_stretch #(
        .HOLD_CYCLES(LED_HOLD_CYCLES_P)
    ) u_led_stretch (
        .sys_clk(sys_clk),
        .rst(rst),
        .trigger(led_trigger),
        .led_n(activity_led_n)
    );

endmodule // lpmc_sequencer

`default_nettype wire

// ### test/lpmc_checker.sv
// Port checker for the low-power mode sequencer
`timescale 1ns/1ps
`default_nettype none
module lpmc_checker
#(
    parameter int unsigned CAL_CYCLES_P = 20,
    parameter int unsigned LED_HOLD_CYCLES_P = 10
)
(
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic sleep_n_pin,
    input wire logic tx_event,
    input wire logic rx_event,
    input wire logic collision_event,
    input wire logic cfg_load_done,
    input wire lpmc_pkg::lpmc_host_req_t host_req,
    input wire lpmc_pkg::lpmc_host_rsp_t host_rsp,
    input wire lpmc_pkg::lpmc_power_ctl_t power_ctl,
    input wire logic cfg_load_start,
    input wire logic activity_led_n,
    input wire logic init_complete,
    input wire logic serial_if_busy
);
    import lpmc_pkg::*;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    logic [19:0] cal_cnt_reg;
    logic [19:0] low_cnt_reg;
    logic any_event;
    assign any_event = tx_event || rx_event || collision_event;
    // Cycles since core reset fell, and cycles the LED has been lit
    always_ff @(posedge sys_clk)
    begin
        cal_cnt_reg <= power_ctl.core_reset ? 20'h0_0000 : cal_cnt_reg + 20'h0_0001;
        low_cnt_reg <= activity_led_n ? 20'h0_0000 : low_cnt_reg + 20'h0_0001;
    end
    property p_read_answer;
        host_req.sel && host_req.rd && !power_ctl.bus_ignore |=> host_rsp.valid;
    endproperty
    a_read_answer: assert property (p_read_answer) else $error("read not answered");
    property p_led_on;
        any_event && init_complete && !power_ctl.net_ignore && !power_ctl.core_reset |=> !activity_led_n;
    endproperty
    a_led_on: assert property (p_led_on) else $error("led not lit");
    property p_led_hold;
        $fell(activity_led_n) |-> (!activity_led_n) [*8];
    endproperty
    a_led_hold: assert property (p_led_hold) else $error("led pulse short");
    property p_led_release;
        $rose(activity_led_n) && !$past(rst) |-> low_cnt_reg >= 20'(LED_HOLD_CYCLES_P);
    endproperty
    a_led_release: assert property (p_led_release) else $error("led released early");
    property p_init_done;
        $rose(init_complete) |-> $fell(serial_if_busy) && $past(cfg_load_done);
    endproperty
    a_init_done: assert property (p_init_done) else $error("init flags wrong");
    property p_cal_len;
        cfg_load_start |-> cal_cnt_reg == 20'(CAL_CYCLES_P - 1);
    endproperty
    a_cal_len: assert property (p_cal_len) else $error("calibration length wrong");
    property p_isolate_entry;
        $rose(power_ctl.core_isolate) |-> !$past(sleep_n_pin, 3);
    endproperty
    a_isolate_entry: assert property (p_isolate_entry) else $error("suspend timing wrong");
    property p_isolate_wake;
        (power_ctl.core_isolate && sleep_n_pin) [*3] |=> power_ctl.core_reset && !power_ctl.core_isolate;
    endproperty
    a_isolate_wake: assert property (p_isolate_wake) else $error("suspend exit wrong");
    c_isolate: cover property ($rose(power_ctl.core_isolate));
    c_init: cover property ($rose(init_complete));
    c_led: cover property ($fell(activity_led_n));
endmodule // lpmc_checker
bind lpmc_sequencer lpmc_checker
#(
    .CAL_CYCLES_P(CAL_CYCLES_P),
    .LED_HOLD_CYCLES_P(LED_HOLD_CYCLES_P)
)
u_lpmc_checker
(
    .sys_clk(sys_clk), .rst(rst), .sleep_n_pin(sleep_n_pin), .tx_event(tx_event), .rx_event(rx_event),
    .collision_event(collision_event), .cfg_load_done(cfg_load_done), .host_req(host_req),
    .host_rsp(host_rsp), .power_ctl(power_ctl), .cfg_load_start(cfg_load_start),
    .activity_led_n(activity_led_n), .init_complete(init_complete), .serial_if_busy(serial_if_busy)
);
`default_nettype wire

// ### test/lpmc_cfg_mem_model.sv
// Configuration memory model answering read-out requests
`timescale 1ns/1ps
`default_nettype none
module lpmc_cfg_mem_model
(
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic slow,
    input wire logic cfg_load_start,
    output logic cfg_load_done
);
    logic [3:0] left_reg;
    // Read-out takes one cycle when prompt, nine when slow
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            left_reg <= 4'h0;
        end
        else if (cfg_load_start)
        begin
            left_reg <= slow ? 4'h9 : 4'h1;
        end
        else if (left_reg != 4'h0)
        begin
            left_reg <= left_reg - 4'h1;
        end
    end
    assign cfg_load_done = (left_reg == 4'h1);
endmodule // lpmc_cfg_mem_model
`default_nettype wire

// ### test/lpmc_sequencer_bench.sv
// Self-checking bench for the low-power mode sequencer
`timescale 1ns/1ps
`default_nettype none
module lpmc_sequencer_bench;
    import lpmc_pkg::*;
    localparam int unsigned HOLD = 10;
    logic sys_clk, rst, sleep_n, link, tx, rx, col, slow, done, start, led_n, init, busy, got_v;
    logic [15:0] rdat;
    lpmc_host_req_t req;
    lpmc_host_rsp_t rsp;
    lpmc_power_ctl_t pwr;
    int n_mismatch = 0;
    int check_count = 0;
    int cycles = 0;
    lpmc_sequencer #(.CAL_CYCLES_P(20), .LED_HOLD_CYCLES_P(HOLD)) dut
    (
        .sys_clk(sys_clk), .rst(rst), .sleep_n_pin(sleep_n), .link_activity_pin(link), .tx_event(tx),
        .rx_event(rx), .collision_event(col), .cfg_load_done(done), .host_req(req), .host_rsp(rsp),
        .power_ctl(pwr), .cfg_load_start(start), .activity_led_n(led_n), .init_complete(init),
        .serial_if_busy(busy)
    );
    lpmc_cfg_mem_model mem
    (
        .sys_clk(sys_clk), .rst(rst), .slow(slow), .cfg_load_start(start), .cfg_load_done(done)
    );
    initial
    begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    task automatic cyc(input logic w, input logic [9:0] a, input logic [15:0] d);
        @(posedge sys_clk);
        req <= '{sel: 1'b1, wr: w, rd: ~w, addr: a, wdata: d};
        @(posedge sys_clk);
        req <= '0;
        #1;
        got_v = rsp.valid;
        rdat = rsp.rdata;
    endtask
    task automatic rd_chk(input logic [9:0] a, input logic [15:0] exp);
        cyc(1'b0, a, 16'h0000);
        chk({15'h0, got_v}, 16'h0001);
        chk(rdat, exp);
    endtask
    task automatic ev(input logic [2:0] b);
        @(posedge sys_clk);
        {tx, rx, col} <= b;
        @(posedge sys_clk);
        {tx, rx, col} <= 3'h0;
    endtask
    task automatic pin(input logic v);
        @(posedge sys_clk);
        sleep_n <= v;
        tick(3);
    endtask
    task automatic wait_init();
        for (int i = 0; i < 200 && init !== 1'b1; i++)
        begin
            tick(1);
        end
        chk({14'h0, init, busy}, 16'h0002);
    endtask
    task automatic t_regs();
        wait_init();
        rd_chk(SELF_STATUS_OFFSET, 16'h0080);
        rd_chk(SELF_CONTROL_OFFSET, SELF_CONTROL_RESET);
        rd_chk(10'h3FE, 16'h0000);
        cyc(1'b1, IO_BASE_OFFSET, 16'h1234);
        rd_chk(IO_BASE_OFFSET, 16'h1234);
    endtask
    task automatic t_led();
        int n;
        for (int k = 0; k < 3; k++)
        begin
            ev(3'h4 >> k);
            n = 0;
            #1;
            while (led_n === 1'b0 && n < 50)
            begin
                tick(1);
                n++;
            end
            chk(16'(n), 16'(HOLD));
        end
    endtask
    task automatic t_standby();
        cyc(1'b1, IO_BASE_OFFSET, 16'h00AB);
        cyc(1'b1, SELF_CONTROL_OFFSET, 16'h0600);
        pin(1'b0);
        chk({12'h0, pwr.core_reset, pwr.bus_ignore, pwr.analog_on, pwr.rx_listen}, 16'h000D);
        cyc(1'b0, SELF_CONTROL_OFFSET, 16'h0000);
        chk({14'h0, got_v, init}, 16'h0000);
        ev(3'h7);
        tick(2);
        chk({15'h0, led_n}, 16'h0001);
        @(posedge sys_clk);
        link <= 1'b1;
        tick(4);
        chk({15'h0, led_n}, 16'h0000);
        @(posedge sys_clk);
        link <= 1'b0;
        tick(HOLD + 6);
        pin(1'b1);
        wait_init();
        rd_chk(SELF_CONTROL_OFFSET, 16'h0600);
        rd_chk(IO_BASE_OFFSET, 16'h0000);
    endtask
    task automatic t_sleep();
        slow = 1'b1;
        cyc(1'b1, IO_BASE_OFFSET, 16'h0055);
        cyc(1'b1, SELF_CONTROL_OFFSET, 16'h0300);
        tick(2);
        rd_chk(IO_BASE_OFFSET, 16'h0055);
        rd_chk(SELF_STATUS_OFFSET, 16'h0000);
        pin(1'b0);
        chk({13'h0, pwr.core_isolate, pwr.net_ignore, pwr.rx_listen}, 16'h0006);
        ev(3'h7);
        cyc(1'b0, IO_BASE_OFFSET, 16'h0000);
        chk({14'h0, got_v, led_n}, 16'h0001);
        pin(1'b1);
        tick(4);
        cyc(1'b1, IO_BASE_OFFSET, 16'hFFFF);
        wait_init();
        rd_chk(IO_BASE_OFFSET, 16'h0055);
        rd_chk(SELF_CONTROL_OFFSET, 16'h0200);
    endtask
    task automatic t_hwreset();
        pin(1'b0);
        chk({15'h0, pwr.core_isolate}, 16'h0001);
        @(posedge sys_clk);
        rst <= 1'b1;
        tick(2);
        @(posedge sys_clk);
        rst <= 1'b0;
        wait_init();
        chk({15'h0, pwr.core_isolate}, 16'h0000);
        rd_chk(SELF_CONTROL_OFFSET, 16'h0000);
        @(posedge sys_clk);
        sleep_n <= 1'b1;
    endtask
    task automatic results();
        $display("mismatches=%0d checks=%0d", n_mismatch, check_count);
        if (n_mismatch == 0 && check_count > 0)
        begin
            $display("Result: passed");
        end
        else
        begin
            $display("Result: failed");
        end
        $finish;
    endtask
    always @(posedge sys_clk)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            n_mismatch++;
            results();
        end
    end
    initial
    begin
        rst = 1'b1;
        sleep_n = 1'b1;
        link = 1'b0;
        {tx, rx, col} = 3'h0;
        slow = 1'b0;
        req = '0;
        repeat (5) @(posedge sys_clk);
        rst <= 1'b0;
        t_regs();
        t_led();
        t_standby();
        t_sleep();
        t_hwreset();
        results();
    end
endmodule // lpmc_sequencer_bench
`default_nettype wire
